/* common/clk_override_pkg.sv */
// Register map, field positions and timing for the core clock override block
package clk_override_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  CTRL_OFS      = 8'h00;  // spare control word
  localparam logic [7:0]  STAT_OFS      = 8'h04;  // clock switch status
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
  localparam int          SYSDIV_DIS_B  = 3;
  localparam int          FBDIV_DIS_B   = 2;
  localparam int          SYSDIV_RST_B  = 1;
  localparam int          CLK_SEL_RC_B  = 0;
  localparam int          STAT_STATE_LO = 0;      // status[1:0] switch state
  localparam int          STAT_SEL_B    = 2;      // status[2] rc selected
  localparam int          STAT_SYSG_B   = 3;      // status[3] system gate open
  localparam int          STAT_RCG_B    = 4;      // status[4] rc gate open
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          GATE_GAP_NS   = 20;     // both gates shut this long
  localparam int          GATE_CYCLES   = (GATE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 4;

  typedef enum logic [1:0] {
    ST_SYS    = 2'b00,
    ST_TO_RC  = 2'b01,
    ST_RC     = 2'b10,
    ST_TO_SYS = 2'b11
  } clk_state_e;
endpackage : clk_override_pkg

/* hw/core_clock_override.sv */
// Spare control word with core clock and divider override controls
// Behaviour
// - 32-bit read/write control word, resets zero
// - Bit 3 forces system divider enable low
// - Bit 2 forces APLL feedback enable low
// - Bit 1 holds system divider in reset
// - Bit 0 glitch-free switch to RC clock
module core_clock_override
  import clk_override_pkg::*;
#(
  parameter bit OVERRIDE_EN = 1'b1  // Variant with override bits active
) (
  input  wire logic              clk,           // 100 MHz clock
  input  wire logic              rst_b,         // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr,          // Register byte address
  input  wire logic [DATA_W-1:0] wr_data,       // Write data
  input  wire logic              wr_en,         // Write strobe
  input  wire logic              rd_en,         // Read strobe
  input  wire logic              sysdiv_en_in,  // Normal system divider enable
  input  wire logic              fbdiv_en_in,   // Normal feedback divider enable
  output logic [DATA_W-1:0]      rd_data,       // Read data, cycle after strobe
  output logic                   sysdiv_en,     // System divider enable
  output logic                   fbdiv_en,      // APLL feedback divider enable
  output logic                   sysdiv_rst,    // System divider reset, high
  output logic                   core_sel_rc,   // Core clock mux selects RC
  output logic                   sys_clk_gate,  // System clock gate open
  output logic                   rc_clk_gate    // RC clock gate open
);

  localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GATE_CYCLES - 1);

  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] rd_data_r;
  logic              sysdiv_en_r;
  logic              fbdiv_en_r;
  logic              sysdiv_rst_r;
  logic              sel_rc_r;
  logic              sys_gate_r;
  logic              rc_gate_r;
  logic [CNT_W-1:0]  cnt_r;
  clk_state_e        state_r;
  logic              want_rc;
  logic [DATA_W-1:0] status;

  // Override bit is live only in the variant that has it
  function automatic logic ovr(input logic [DATA_W-1:0] w, input int b);
    ovr = OVERRIDE_EN & w[b];
  endfunction : ovr

  assign want_rc = ovr(ctrl_r, CLK_SEL_RC_B);

  // Status word: switch state and gate view
  always_comb begin
    status                              = RD_ZERO;
    status[STAT_STATE_LO +: 2]          = state_r;
    status[STAT_SEL_B]                  = sel_rc_r;
    status[STAT_SYSG_B]                 = sys_gate_r;
    status[STAT_RCG_B]                  = rc_gate_r;
  end

  // Control word storage, all 32 bits kept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_en && addr == CTRL_OFS) begin
      ctrl_r <= wr_data;
    end
  end

  // Read port, data one cycle after strobe, unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= RD_ZERO;
    end else if (rd_en) begin
      case (addr)
        CTRL_OFS: rd_data_r <= ctrl_r;
        STAT_OFS: rd_data_r <= status;
        default:  rd_data_r <= RD_ZERO;
      endcase
    end else begin
      rd_data_r <= RD_ZERO;
    end
  end

  // Divider enable and reset overrides
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sysdiv_en_r  <= 1'b0;
      fbdiv_en_r   <= 1'b0;
      sysdiv_rst_r <= 1'b0;
    end else begin
      sysdiv_en_r  <= sysdiv_en_in & ~ovr(ctrl_r, SYSDIV_DIS_B);
      fbdiv_en_r   <= fbdiv_en_in & ~ovr(ctrl_r, FBDIV_DIS_B);
      sysdiv_rst_r <= ovr(ctrl_r, SYSDIV_RST_B);
    end
  end

  // Break-before-make clock switch: shut both gates, then move mux and open one on the same edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= ST_SYS;
      cnt_r      <= '0;
      sel_rc_r   <= 1'b0;
      sys_gate_r <= 1'b1;
      rc_gate_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_SYS: begin
          if (want_rc) begin
            state_r    <= ST_TO_RC;
            cnt_r      <= GAP_LOAD;
            sys_gate_r <= 1'b0;
          end
        end
        ST_TO_RC: begin
          if (cnt_r == '0) begin
            state_r   <= ST_RC;
            sel_rc_r  <= 1'b1;
            rc_gate_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_RC: begin
          if (!want_rc) begin
            state_r   <= ST_TO_SYS;
            cnt_r     <= GAP_LOAD;
            rc_gate_r <= 1'b0;
          end
        end
        ST_TO_SYS: begin
          if (cnt_r == '0) begin
            state_r    <= ST_SYS;
            sel_rc_r   <= 1'b0;
            sys_gate_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r    <= ST_SYS;
          sel_rc_r   <= 1'b0;
          sys_gate_r <= 1'b1;
          rc_gate_r  <= 1'b0;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign rd_data      = rd_data_r;
  assign sysdiv_en    = sysdiv_en_r;
  assign fbdiv_en     = fbdiv_en_r;
  assign sysdiv_rst   = sysdiv_rst_r;
  assign core_sel_rc  = sel_rc_r;
  assign sys_clk_gate = sys_gate_r;
  assign rc_clk_gate  = rc_gate_r;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Both gates shut for the gap, then the target gate opens
  sequence s_gap;
    (!sys_gate_r && !rc_gate_r) [*2];
  endsequence
  sequence s_rc_on;
    rc_gate_r && sel_rc_r && !sys_gate_r;
  endsequence
  sequence s_sys_on;
    sys_gate_r && !sel_rc_r && !rc_gate_r;
  endsequence

  a_ctrl_write_store: assert property (
    (wr_en && addr == CTRL_OFS) |=> ctrl_r == $past(wr_data))
    else $error("control word did not take the write");

  a_ctrl_read_back: assert property (
    (rd_en && addr == CTRL_OFS) |=> rd_data == $past(ctrl_r))
    else $error("control word read returned wrong data");

  a_read_idle_zero: assert property (
    !rd_en |=> rd_data == RD_ZERO)
    else $error("read data not zero outside read answer");

  a_sysdiv_forced_off: assert property (
    (OVERRIDE_EN && ctrl_r[SYSDIV_DIS_B]) |=> !sysdiv_en)
    else $error("system divider enable not forced low");

  a_fbdiv_forced_off: assert property (
    (OVERRIDE_EN && ctrl_r[FBDIV_DIS_B]) |=> !fbdiv_en)
    else $error("feedback divider enable not forced low");

  a_fbdiv_passes: assert property (
    !(OVERRIDE_EN && ctrl_r[FBDIV_DIS_B]) |=> fbdiv_en == $past(fbdiv_en_in))
    else $error("feedback divider enable not following input");

  a_sysdiv_reset_held: assert property (
    sysdiv_rst == (OVERRIDE_EN && $past(ctrl_r[SYSDIV_RST_B])))
    else $error("system divider reset not following bit 1");

  a_gates_exclusive: assert property (
    !(sys_gate_r && rc_gate_r))
    else $error("both clock gates open at once");

  a_switch_to_rc: assert property (
    (state_r == ST_SYS && want_rc) |=> s_gap ##1 s_rc_on)
    else $error("switch to RC clock sequence wrong");

  a_switch_to_sys: assert property (
    (state_r == ST_RC && !want_rc) |=> s_gap ##1 s_sys_on)
    else $error("switch back to system clock sequence wrong");

  a_variant_inert: assert property (
    !OVERRIDE_EN |-> (!sysdiv_rst && !sel_rc_r))
    else $error("override bits acted in variant without them");

  // Register port checks
  a_ctrl_hold_idle: assert property (
    !(wr_en && addr == CTRL_OFS) |=> $stable(ctrl_r))
    else $error("control word changed without a write");

  a_write_other_ignored: assert property (
    (wr_en && addr != CTRL_OFS) |=> $stable(ctrl_r))
    else $error("write to other address changed control word");

  a_status_read_back: assert property (
    (rd_en && addr == STAT_OFS) |=> rd_data == $past(status))
    else $error("status read returned wrong data");

  a_unmapped_read_zero: assert property (
    (rd_en && addr != CTRL_OFS && addr != STAT_OFS) |=> rd_data == RD_ZERO)
    else $error("unmapped read did not return zero");

  // Divider override checks
  a_sysdiv_passes: assert property (
    !(OVERRIDE_EN && ctrl_r[SYSDIV_DIS_B]) |=> sysdiv_en == $past(sysdiv_en_in))
    else $error("system divider enable not following input");

  a_high_bits_inert: assert property (
    ($past(rst_b) && $stable(ctrl_r[SYSDIV_DIS_B:CLK_SEL_RC_B])
      && $stable(sysdiv_en_in) && $stable(fbdiv_en_in))
      |=> ($stable(sysdiv_en) && $stable(fbdiv_en) && $stable(sysdiv_rst)))
    else $error("upper control bits changed divider outputs");

  a_sysdiv_rst_release: assert property (
    (OVERRIDE_EN && $fell(ctrl_r[SYSDIV_RST_B])) |=> !sysdiv_rst)
    else $error("system divider reset not released");

  // Clock switch checks
  a_gates_shut_between: assert property (
    (state_r == ST_TO_RC || state_r == ST_TO_SYS) |-> (!sys_gate_r && !rc_gate_r))
    else $error("a clock gate open during a switch");

  a_sys_state_view: assert property (
    state_r == ST_SYS |-> s_sys_on)
    else $error("system clock state with wrong gates");

  a_rc_state_view: assert property (
    state_r == ST_RC |-> s_rc_on)
    else $error("RC clock state with wrong gates");

  a_sel_moves_shut: assert property (
    $changed(sel_rc_r) |-> (!$past(sys_gate_r) && !$past(rc_gate_r)))
    else $error("clock select moved while a gate was open");

  a_rc_gate_after_gap: assert property (
    $rose(rc_gate_r) |-> (!$past(sys_gate_r, 1) && !$past(sys_gate_r, 2)))
    else $error("RC gate opened without full gap");

  a_sys_gate_after_gap: assert property (
    $rose(sys_gate_r) |-> (!$past(rc_gate_r, 1) && !$past(rc_gate_r, 2)))
    else $error("system gate opened without full gap");

  a_sel_in_transition: assert property (
    $changed(sel_rc_r) |-> ($past(state_r) == ST_TO_RC || $past(state_r) == ST_TO_SYS))
    else $error("clock select moved outside a switch");

  a_rc_held_steady: assert property (
    (state_r == ST_RC && want_rc) |=> state_r == ST_RC)
    else $error("left RC clock while bit 0 high");

  a_sys_held_steady: assert property (
    (state_r == ST_SYS && !want_rc) |=> state_r == ST_SYS)
    else $error("left system clock while bit 0 low");

  a_gap_count_range: assert property (
    cnt_r <= GAP_LOAD)
    else $error("gap counter out of range");

  a_to_rc_step: assert property (
    (state_r == ST_TO_RC && cnt_r != '0) |=> state_r == ST_TO_RC)
    else $error("switch to RC ended before gap");

  a_to_sys_step: assert property (
    (state_r == ST_TO_SYS && cnt_r != '0) |=> state_r == ST_TO_SYS)
    else $error("switch to system clock ended before gap");

endmodule : core_clock_override

/* verif/core_clock_override_bench.sv */
// Self-checking bench for the core clock override control word
module core_clock_override_bench
  import clk_override_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk, rst_b, wr_en, rd_en, sysdiv_en_in, fbdiv_en_in;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, ctrl, d;
  logic              sysdiv_en, fbdiv_en, sysdiv_rst, core_sel_rc, sys_clk_gate, rc_clk_gate;
  logic [DATA_W-1:0] exp_q[$];
  logic              rd_seen;
  int                bad_count, n_checks, seed;

  core_clock_override i_core_clock_override (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .sysdiv_en_in(sysdiv_en_in),
    .fbdiv_en_in(fbdiv_en_in), .rd_data(rd_data), .sysdiv_en(sysdiv_en),
    .fbdiv_en(fbdiv_en), .sysdiv_rst(sysdiv_rst), .core_sel_rc(core_sel_rc),
    .sys_clk_gate(sys_clk_gate), .rc_clk_gate(rc_clk_gate));

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // One-cycle write strobe; tracks the control word
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wr_data <= v; wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    if (a == CTRL_OFS) ctrl = v;
  endtask : wr

  // One-cycle read strobe; expectation queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd

  // Clock select change, then break-before-make timing
  task automatic sw(input logic v);
    wr(CTRL_OFS, {ctrl[31:1], v});
    @(posedge clk); #1;
    chk("closing gate", v ? sys_clk_gate : rc_clk_gate, 0);
    chk("select early", core_sel_rc, !v);
    @(posedge clk); @(posedge clk); #1;
    chk("select", core_sel_rc, v);
    chk("rc gate", rc_clk_gate, v);
    chk("sys gate", sys_clk_gate, !v);
  endtask : sw

  // Read answers and gate overlap watched at falling edges
  always @(negedge clk) begin
    if (rd_seen) chk("rd_data", rd_data, exp_q.pop_front());
    rd_seen = rd_en;
    if (rst_b) chk("gate overlap", sys_clk_gate & rc_clk_gate, 0);
  end

  // Watchdog
  initial begin
    #200us;
    bad_count++;
    finish_test();
  end

  initial begin
    {rst_b, wr_en, rd_en, rd_seen, sysdiv_en_in, fbdiv_en_in} = '0;
    addr = '0; wr_data = '0; ctrl = '0; seed = 74;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(CTRL_OFS, CTRL_RST);
    rd(STAT_OFS, 32'h0000_0008);
    // Upper bits only store; unmapped places ignored
    repeat (8) begin
      d = $random(seed);
      wr(CTRL_OFS, {d[31:4], 4'h0});
      wr(8'h10, ~d);
      rd(CTRL_OFS, ctrl);
      rd(8'h10, RD_ZERO);
    end
    sw(1'b1);
    rd(STAT_OFS, 32'h0000_0016);
    // Overrides while on the RC clock, random enables
    repeat (16) begin
      d = $random(seed);
      @(posedge clk);
      sysdiv_en_in <= d[5]; fbdiv_en_in <= d[4];
      wr(CTRL_OFS, {d[31:1], 1'b1});
      @(posedge clk); #1;
      chk("sysdiv_en", sysdiv_en, d[5] & ~d[3]);
      chk("fbdiv_en", fbdiv_en, d[4] & ~d[2]);
      chk("sysdiv_rst", sysdiv_rst, d[1]);
      rd(CTRL_OFS, ctrl);
    end
    // Divider reset pulse, then return to the system clock
    wr(CTRL_OFS, 32'h0000_0003);
    @(posedge clk); #1;
    chk("sysdiv_rst on", sysdiv_rst, 1);
    wr(CTRL_OFS, 32'h0000_0001);
    @(posedge clk); #1;
    chk("sysdiv_rst off", sysdiv_rst, 0);
    sw(1'b0);
    rd(STAT_OFS, 32'h0000_0008);
    // Mid-run reset clears the word and reopens the system gate
    wr(CTRL_OFS, 32'hA5A5_5A50);
    rst_b <= 1'b0;
    @(posedge clk); #1;
    chk("reset sel", core_sel_rc, 0);
    chk("reset gates", {sys_clk_gate, rc_clk_gate}, 32'h0000_0002);
    chk("reset dividers", {sysdiv_en, fbdiv_en, sysdiv_rst}, 0);
    chk("reset rd_data", rd_data, RD_ZERO);
    @(posedge clk);
    rst_b <= 1'b1;
    ctrl = CTRL_RST;
    rd(CTRL_OFS, CTRL_RST);
    rd(STAT_OFS, 32'h0000_0008);
    repeat (4) @(posedge clk);
    chk("pending reads", exp_q.size(), 0);
    finish_test();
  end
endmodule : core_clock_override_bench
